// >>> rtl/bcs_regs.vh
`ifndef BCS_REGS_VH
`define BCS_REGS_VH
// opcode bytes
`define BCS_PREFIX      8'hed
`define BCS_OP_CMP_ASC  8'ha1
`define BCS_OP_CMP_ASCR 8'hb1
`define BCS_OP_CMP_DSC  8'ha9
`define BCS_OP_CMP_DSCR 8'hb9
`define BCS_OP_MOV_DSCR 8'hb8
// flag bit positions in the flag byte
`define BCS_FLAG_CARRY  0
`define BCS_FLAG_SUB    1
`define BCS_FLAG_PV     2
`define BCS_FLAG_HALF   4
`define BCS_FLAG_ZERO   6
`define BCS_FLAG_SIGN   7
// t-state counts of each machine cycle
`define BCS_T_M1        3'd4
`define BCS_T_M2        3'd4
`define BCS_T_M3        3'd3
`define BCS_T_M4        3'd5
`define BCS_T_M5        3'd5
`endif

// >>> rtl/bcs_unit.v
// Notes on behaviour
// - compare reads memory, changes neither operand
// - ascending single: pointer up, counter down
// - descending single: pointer and counter down
// - zero flag set on equality
// - half-carry set on borrow from bit four
// - sign from result, subtract set, carry kept
// - parity/overflow set while counter-1 nonzero
// - repeat ends on zero count or match
// - unfinished repeat rewinds program counter by two
// - interrupts and two refreshes between iterations
// - zero count wraps, searches whole space
// - continuing iteration: 5 cycles, 21 states
// - final/single: 4 cycles, 16 states
// - move ends zero count, pointers below block
// - move copies source to destination, decrements
`timescale 1ns/100ps
`include "bcs_regs.vh"

module bcs_unit (
	clk,
	reset,
	start,
	opPrefix,
	opCode,
	accIn,
	flagsIn,
	hlIn,
	bcIn,
	deIn,
	pcIn,
	memRdData,
	memAddr,
	memRdStb,
	memWrStb,
	memWrData,
	refreshStb,
	intWindow,
	hlOut,
	bcOut,
	deOut,
	pcOut,
	flagsOut,
	busy,
	done,
	badOp,
	mCycle,
	tState
);
	input         clk;
	input         reset;
	input         start;
	input  [7:0]  opPrefix;
	input  [7:0]  opCode;
	input  [7:0]  accIn;
	input  [7:0]  flagsIn;
	input  [15:0] hlIn;
	input  [15:0] bcIn;
	input  [15:0] deIn;
	input  [15:0] pcIn;
	input  [7:0]  memRdData;
	output [15:0] memAddr;
	output        memRdStb;
	output        memWrStb;
	output [7:0]  memWrData;
	output        refreshStb;
	output        intWindow;
	output [15:0] hlOut;
	output [15:0] bcOut;
	output [15:0] deOut;
	output [15:0] pcOut;
	output [7:0]  flagsOut;
	output        busy;
	output        done;
	output        badOp;
	output [2:0]  mCycle;
	output [2:0]  tState;

	// ------------------------------------------------------------
	// sequencer state codes
	// ------------------------------------------------------------
	localparam ST_IDLE = 1'b0;
	localparam ST_RUN  = 1'b1;

	reg        state_ff;
	reg [15:0] memAddr_ff;
	reg        memRdStb_ff;
	reg        memWrStb_ff;
	reg [7:0]  memWrData_ff;
	reg        refreshStb_ff;
	reg        intWindow_ff;
	reg [15:0] hlOut_ff;
	reg [15:0] bcOut_ff;
	reg [15:0] deOut_ff;
	reg [15:0] pcOut_ff;
	reg [7:0]  flagsOut_ff;
	reg        busy_ff;
	reg        done_ff;
	reg        badOp_ff;
	reg [2:0]  mCycle_ff;
	reg [2:0]  tState_ff;
	reg        isMove_ff;
	reg        isDown_ff;
	reg        isRepeat_ff;
	reg [7:0]  acc_ff;
	reg [7:0]  dataByte_ff;
	reg        lastIter_ff;

	// ------------------------------------------------------------
	// opcode decode
	// ------------------------------------------------------------
	function opKnown;
		input [7:0] pre;
		input [7:0] op;
		begin
			opKnown = (pre == `BCS_PREFIX) &&
				(op == `BCS_OP_CMP_ASC || op == `BCS_OP_CMP_ASCR ||
				 op == `BCS_OP_CMP_DSC || op == `BCS_OP_CMP_DSCR ||
				 op == `BCS_OP_MOV_DSCR);
		end
	endfunction

	// t-states in a given machine cycle
	function [2:0] mLen;
		input [2:0] m;
		begin
			case (m)
				3'd1: mLen = `BCS_T_M1;
				3'd2: mLen = `BCS_T_M2;
				3'd3: mLen = `BCS_T_M3;
				3'd4: mLen = `BCS_T_M4;
				default: mLen = `BCS_T_M5;
			endcase
		end
	endfunction

	// ------------------------------------------------------------
	// arithmetic for the step
	// ------------------------------------------------------------
	wire [8:0]  diff    = {1'b0, acc_ff} - {1'b0, dataByte_ff};
	wire [4:0]  lowDiff = {1'b0, acc_ff[3:0]} - {1'b0, dataByte_ff[3:0]};
	wire        match   = (acc_ff == dataByte_ff);
	// a zero count wraps to ffff, so the search runs through all of memory
	wire [15:0] bcDec   = bcOut_ff - 16'h0001;
	wire        bcLeft  = (bcDec != 16'h0000);
	wire        stopNow = isMove_ff ? !bcLeft :
		(!isRepeat_ff || !bcLeft || match);
	wire        lastT   = (tState_ff == mLen(mCycle_ff));

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	always @(posedge clk) begin
		if (reset) begin
			state_ff      <= ST_IDLE;
			memAddr_ff    <= 16'h0000;
			memRdStb_ff   <= 1'b0;
			memWrStb_ff   <= 1'b0;
			memWrData_ff  <= 8'h00;
			refreshStb_ff <= 1'b0;
			intWindow_ff  <= 1'b0;
			hlOut_ff      <= 16'h0000;
			bcOut_ff      <= 16'h0000;
			deOut_ff      <= 16'h0000;
			pcOut_ff      <= 16'h0000;
			flagsOut_ff   <= 8'h00;
			busy_ff       <= 1'b0;
			done_ff       <= 1'b0;
			badOp_ff      <= 1'b0;
			mCycle_ff     <= 3'd0;
			tState_ff     <= 3'd0;
			isMove_ff     <= 1'b0;
			isDown_ff     <= 1'b0;
			isRepeat_ff   <= 1'b0;
			acc_ff        <= 8'h00;
			dataByte_ff   <= 8'h00;
			lastIter_ff   <= 1'b0;
		end else begin
			memRdStb_ff   <= 1'b0;
			memWrStb_ff   <= 1'b0;
			refreshStb_ff <= 1'b0;
			intWindow_ff  <= 1'b0;
			done_ff       <= 1'b0;
			badOp_ff      <= 1'b0;
			case (state_ff)
				ST_IDLE: begin
					if (start) begin
						if (opKnown(opPrefix, opCode)) begin
							state_ff    <= ST_RUN;
							busy_ff     <= 1'b1;
							isMove_ff   <= (opCode == `BCS_OP_MOV_DSCR);
							isDown_ff   <= opCode[3];
							isRepeat_ff <= opCode[4];
							acc_ff      <= accIn;
							hlOut_ff    <= hlIn;
							bcOut_ff    <= bcIn;
							deOut_ff    <= deIn;
							pcOut_ff    <= pcIn;
							flagsOut_ff <= flagsIn;
							mCycle_ff   <= 3'd1;
							tState_ff   <= 3'd1;
						end else begin
							badOp_ff <= 1'b1;
						end
					end
				end
				ST_RUN: begin
					tState_ff <= lastT ? 3'd1 : tState_ff + 3'd1;
					// two prefix/opcode fetch cycles each end in a refresh
					if (lastT && (mCycle_ff == 3'd1 || mCycle_ff == 3'd2))
						refreshStb_ff <= 1'b1;
					if (mCycle_ff == 3'd3 && tState_ff == 3'd1) begin
						memAddr_ff  <= hlOut_ff;
						memRdStb_ff <= 1'b1;
					end
					if (mCycle_ff == 3'd3 && lastT)
						dataByte_ff <= memRdData;
					if (mCycle_ff == 3'd4 && tState_ff == 3'd1 && isMove_ff) begin
						memAddr_ff   <= deOut_ff;
						memWrData_ff <= dataByte_ff;
						memWrStb_ff  <= 1'b1;
					end
					if (lastT) begin
						mCycle_ff <= mCycle_ff + 3'd1;
						if (mCycle_ff == 3'd4) begin
							bcOut_ff <= bcDec;
							hlOut_ff <= isDown_ff ? hlOut_ff - 16'h0001
								: hlOut_ff + 16'h0001;
							if (isMove_ff) begin
								deOut_ff <= deOut_ff - 16'h0001;
								flagsOut_ff[`BCS_FLAG_HALF] <= 1'b0;
								flagsOut_ff[`BCS_FLAG_SUB]  <= 1'b0;
							end else begin
								flagsOut_ff[`BCS_FLAG_ZERO] <= match;
								flagsOut_ff[`BCS_FLAG_HALF] <= lowDiff[4];
								flagsOut_ff[`BCS_FLAG_SIGN] <= diff[7];
								flagsOut_ff[`BCS_FLAG_SUB]  <= 1'b1;
							end
							flagsOut_ff[`BCS_FLAG_PV] <= bcLeft;
							lastIter_ff <= stopNow;
							if (stopNow) begin
								state_ff  <= ST_IDLE;
								busy_ff   <= 1'b0;
								done_ff   <= 1'b1;
								mCycle_ff <= 3'd0;
								tState_ff <= 3'd0;
							end
						end else if (mCycle_ff == 3'd5) begin
							pcOut_ff     <= pcOut_ff - 16'h0002;
							state_ff     <= ST_IDLE;
							busy_ff      <= 1'b0;
							done_ff      <= 1'b1;
							intWindow_ff <= 1'b1;
							mCycle_ff    <= 3'd0;
							tState_ff    <= 3'd0;
						end
					end
				end
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	assign memAddr    = memAddr_ff;
	assign memRdStb   = memRdStb_ff;
	assign memWrStb   = memWrStb_ff;
	assign memWrData  = memWrData_ff;
	assign refreshStb = refreshStb_ff;
	assign intWindow  = intWindow_ff;
	assign hlOut      = hlOut_ff;
	assign bcOut      = bcOut_ff;
	assign deOut      = deOut_ff;
	assign pcOut      = pcOut_ff;
	assign flagsOut   = flagsOut_ff;
	assign busy       = busy_ff;
	assign done       = done_ff;
	assign badOp      = badOp_ff;
	assign mCycle     = mCycle_ff;
	assign tState     = tState_ff;
endmodule // bcs_unit

// >>> tb/bcs_mem.sv
`timescale 1ns/100ps
module bcs_mem (
	input  logic        clk,
	input  logic        memWrStb,
	input  logic [15:0] memAddr,
	input  logic [7:0]  memWrData,
	output logic [7:0]  memRdData
);
	logic [7:0] m [0:65535];
	// reads never alter the array, so a compare cannot disturb memory
	assign memRdData = m[memAddr];
	always @(posedge clk) begin
		if (memWrStb)
			m[memAddr] <= memWrData;
	end
endmodule // bcs_mem

// >>> tb/bcs_unit_props.sv
`timescale 1ns/100ps
module bcs_props (
	input logic        clk, reset, start, busy, done, badOp,
	input logic        intWindow, refreshStb, memRdStb, memWrStb,
	input logic [15:0] memAddr, hlIn, deIn, pcIn, pcOut, bcOut,
	input logic [7:0]  flagsIn, flagsOut,
	input logic [2:0]  mCycle, tState
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	a_run_length: assert property ($rose(busy) |-> ##[16:21] done)
		else $error("done missing");
	a_stop_length: assert property (
		(done && !intWindow) |-> $past(busy, 16) && !$past(busy, 17))
		else $error("final pass length wrong");
	a_cont_length: assert property (
		intWindow |-> $past(busy, 21) && !$past(busy, 22))
		else $error("continuing pass length wrong");
	a_m1_length: assert property (
		(mCycle == 3'd1 && tState == 3'd1) |->
		##3 tState == 3'd4 ##1 (mCycle == 3'd2 && tState == 3'd1))
		else $error("first cycle length wrong");
	a_m4_length: assert property (
		(mCycle == 3'd4 && tState == 3'd1) |->
		##4 (mCycle == 3'd4 && tState == 3'd5))
		else $error("fourth cycle length wrong");
	a_m5_window: assert property (
		(mCycle == 3'd5 && tState == 3'd5) |-> ##[0:1] intWindow)
		else $error("interrupt window missing");
	a_rewind_pc: assert property (
		intWindow |-> done && pcOut == pcIn - 16'h0002)
		else $error("program counter not rewound");
	a_m1_refresh: assert property (
		(mCycle == 3'd1 && tState == 3'd4) |-> ##1 refreshStb)
		else $error("first refresh missing");
	a_two_refresh: assert property (
		(mCycle == 3'd2 && tState == 3'd4) |-> ##[0:1] refreshStb)
		else $error("refresh missing");
	a_read_addr: assert property (
		memRdStb |-> memAddr == hlIn && mCycle == 3'd3)
		else $error("read address wrong");
	a_write_addr: assert property (memWrStb |-> memAddr == deIn)
		else $error("write address wrong");
	a_carry_kept: assert property (done |-> flagsOut[0] == flagsIn[0])
		else $error("carry changed");
	a_pv_count: assert property (
		done |-> flagsOut[2] == (bcOut != 16'h0000))
		else $error("parity flag wrong");
	a_bad_refused: assert property (badOp |-> !busy ##1 !busy)
		else $error("bad opcode started");
	c_cont: cover property (intWindow);
	c_write: cover property (memWrStb);
	c_bad: cover property (badOp);
endmodule // bcs_props
bind bcs_unit bcs_props chk (
	.clk        (clk),
	.reset      (reset),
	.start      (start),
	.busy       (busy),
	.done       (done),
	.badOp      (badOp),
	.intWindow  (intWindow),
	.refreshStb (refreshStb),
	.memRdStb   (memRdStb),
	.memWrStb   (memWrStb),
	.memAddr    (memAddr),
	.hlIn       (hlIn),
	.deIn       (deIn),
	.pcIn       (pcIn),
	.pcOut      (pcOut),
	.bcOut      (bcOut),
	.flagsIn    (flagsIn),
	.flagsOut   (flagsOut),
	.mCycle     (mCycle),
	.tState     (tState)
);

// >>> tb/bcs_unit_bench.sv
`timescale 1ns/100ps
`include "bcs_regs.vh"
module bcs_unit_bench;
	logic        clk, reset, start;
	logic [7:0]  opPrefix, opCode, accIn, flagsIn, r, ef;
	logic [15:0] hlIn, bcIn, deIn, pcIn;
	wire  [7:0]  memRdData, memWrData, flagsOut;
	wire  [15:0] memAddr, hlOut, bcOut, deOut, pcOut;
	wire         memRdStb, memWrStb, refreshStb, intWindow, busy, done, badOp;
	wire  [2:0]  mCycle, tState;
	int          miscompares, testsRun;
	bcs_unit uut (
		.clk        (clk),
		.reset      (reset),
		.start      (start),
		.opPrefix   (opPrefix),
		.opCode     (opCode),
		.accIn      (accIn),
		.flagsIn    (flagsIn),
		.hlIn       (hlIn),
		.bcIn       (bcIn),
		.deIn       (deIn),
		.pcIn       (pcIn),
		.memRdData  (memRdData),
		.memAddr    (memAddr),
		.memRdStb   (memRdStb),
		.memWrStb   (memWrStb),
		.memWrData  (memWrData),
		.refreshStb (refreshStb),
		.intWindow  (intWindow),
		.hlOut      (hlOut),
		.bcOut      (bcOut),
		.deOut      (deOut),
		.pcOut      (pcOut),
		.flagsOut   (flagsOut),
		.busy       (busy),
		.done       (done),
		.badOp      (badOp),
		.mCycle     (mCycle),
		.tState     (tState)
	);
	bcs_mem mem (
		.clk        (clk),
		.memWrStb   (memWrStb),
		.memAddr    (memAddr),
		.memWrData  (memWrData),
		.memRdData  (memRdData)
	);
	// ----
	// tasks
	// ----
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		testsRun++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic reportAndStop;
		$display("checks %0d mismatches %0d", testsRun, miscompares);
		if (miscompares == 0 && testsRun > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic run(input logic [7:0] op);
		@(posedge clk); #1;
		opCode = op;
		start = 1'b1;
		@(posedge clk); #1;
		start = 1'b0;
		repeat (30) if (done !== 1'b1 && badOp !== 1'b1) begin
			@(posedge clk); #1;
		end
		chk(done | badOp, 1'b1);
	endtask
	task automatic cmp(input logic [7:0] op, a, m, input logic [15:0] bc);
		logic [15:0] nb;
		logic        z;
		mem.m[16'h8000] = m;
		accIn = a;
		hlIn = 16'h8000;
		bcIn = bc;
		run(op);
		r = a - m;
		nb = bc - 16'h0001;
		z = (a == m);
		ef = {r[7], z, 1'b0, a[3:0] < m[3:0], 1'b0, nb != 0, 1'b1, 1'b1};
		chk(flagsOut & 8'hd7, ef);
		chk(hlOut, op[3] ? 16'h7fff : 16'h8001);
		chk(bcOut, nb);
		chk(pcOut, (op[4] && nb != 0 && !z) ? pcIn - 16'h0002 : pcIn);
		chk(mem.m[16'h8000], m);
	endtask
	// the unit does one pass per start, so the bench plays the sequencer
	task automatic rep(input logic [7:0] op);
		do begin
			run(op);
			hlIn = hlOut;
			bcIn = bcOut;
			deIn = deOut;
			flagsIn = flagsOut;
		end while (pcOut === pcIn - 16'h0002);
	endtask
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		#400000;
		miscompares++;
		reportAndStop;
	end
	initial begin
		{start, opCode, accIn, hlIn, bcIn, deIn} = '0;
		opPrefix = `BCS_PREFIX;
		flagsIn = 8'h01;
		pcIn = 16'h0200;
		reset = 1'b1;
		repeat (4) @(posedge clk);
		#1 reset = 1'b0;
		cmp(8'ha1, 8'h3b, 8'h3b, 16'h0001);
		cmp(8'ha9, 8'h10, 8'h01, 16'h0002);
		cmp(8'hb1, 8'h00, 8'h01, 16'h0005);
		cmp(8'hb9, 8'h42, 8'h42, 16'h0005);
		cmp(8'hb9, 8'h42, 8'h41, 16'h0000);
		cmp(8'hb1, 8'h42, 8'h41, 16'h0001);
		$display("single compares done");
		{mem.m[16'h1111], mem.m[16'h1112], mem.m[16'h1113]} = 24'h5200f3;
		hlIn = 16'h1111;
		bcIn = 16'h0007;
		accIn = 8'hf3;
		rep(8'hb1);
		chk(hlOut, 16'h1114);
		chk(bcOut, 16'h0004);
		chk(flagsOut & 8'h44, 8'h44);
		{mem.m[16'h1112], mem.m[16'h1113], mem.m[16'h1114]} = 24'h8836a5;
		hlIn = 16'h1114;
		deIn = 16'h2225;
		bcIn = 16'h0003;
		flagsIn = 8'hd7;
		rep(8'hb8);
		chk(hlOut, 16'h1111);
		chk(deOut, 16'h2222);
		chk(bcOut, 16'h0000);
		chk(flagsOut & 8'hd7, 8'hc1);
		for (int i = 0; i < 3; i++)
			chk(mem.m[16'h2223 + i], mem.m[16'h1112 + i]);
		$display("repeat sequences done");
		run(8'h00);
		chk(busy, 1'b0);
		opPrefix = 8'h00;
		run(8'ha1);
		chk(badOp, 1'b1);
		$display("refusals done");
		reportAndStop;
	end
endmodule // bcs_unit_bench
